/* verilog/lcdi_pkg.sv */
package lcdi_pkg;

  localparam int          LCDI_DATA_W         = 32;
  localparam int          LCDI_CONTRAST_W     = 8;
  localparam int          LCDI_SRC_W          = 7;
  localparam int          LCDI_SEL_W          = 6;

  localparam logic [7:0]  LCDI_OFS_CONTRAST   = 8'h00;
  localparam logic [7:0]  LCDI_OFS_EN_SET     = 8'h04;
  localparam logic [7:0]  LCDI_OFS_EN_CLR     = 8'h08;
  localparam logic [7:0]  LCDI_OFS_EN_STATE   = 8'h0c;
  localparam logic [7:0]  LCDI_OFS_PEND_STATE = 8'h10;
  localparam logic [7:0]  LCDI_OFS_PEND_CLR   = 8'h14;

  localparam int          LCDI_SEL_CONTRAST   = 0;
  localparam int          LCDI_SEL_EN_SET     = 1;
  localparam int          LCDI_SEL_EN_CLR     = 2;
  localparam int          LCDI_SEL_EN_STATE   = 3;
  localparam int          LCDI_SEL_PEND_STATE = 4;
  localparam int          LCDI_SEL_PEND_CLR   = 5;

  localparam int          LCDI_BIT_LINE       = 0;
  localparam int          LCDI_BIT_LAST_LINE  = 1;
  localparam int          LCDI_BIT_FRAME_DONE = 2;
  localparam int          LCDI_BIT_UNUSED     = 3;
  localparam int          LCDI_BIT_FIFO_EMPTY = 4;
  localparam int          LCDI_BIT_FIFO_OVR   = 5;
  localparam int          LCDI_BIT_DMA_FAULT  = 6;

  localparam logic [6:0]  LCDI_SRC_VALID      = 7'h77;
  localparam logic [7:0]  LCDI_CONTRAST_RST   = 8'h00;
  localparam logic [6:0]  LCDI_MASK_RST       = 7'h00;
  localparam logic [6:0]  LCDI_PEND_RST       = 7'h00;

  localparam logic [1:0]  LCDI_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  LCDI_RESP_SLVERR    = 2'h2;

  typedef enum logic [1:0] {
    LCDI_WR_IDLE = 2'h1,
    LCDI_WR_RESP = 2'h2
  } lcdi_wr_state_t;

  typedef enum logic [1:0] {
    LCDI_RD_IDLE = 2'h1,
    LCDI_RD_DATA = 2'h2
  } lcdi_rd_state_t;

endpackage

/* verilog/lcdi_irq_bank.sv */
`timescale 1ns/10ps
`default_nettype none
module lcdi_irq_bank
  import lcdi_pkg::*;
#(
  parameter int SRC_W = LCDI_SRC_W
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [SRC_W-1:0] src_event,
  input  wire logic             enable_set_we,
  input  wire logic             enable_clear_we,
  input  wire logic             pending_clear_we,
  input  wire logic [SRC_W-1:0] cmd_bits,
  output logic      [SRC_W-1:0] enable_state,
  output logic      [SRC_W-1:0] pending_state,
  output logic                  irq
);

  if (SRC_W != LCDI_SRC_W) begin : g_width_check
    $error("lcdi_irq_bank: SRC_W must match the source layout");
  end

  logic [SRC_W-1:0] mask_reg;
  logic [SRC_W-1:0] mask_next;
  logic [SRC_W-1:0] pend_reg;
  logic [SRC_W-1:0] pend_next;
  logic             irq_reg;
  logic             irq_next;
  logic [SRC_W-1:0] cmd_valid;

  always_comb begin
    // Unused positions never become enabled or pending
    cmd_valid = cmd_bits & LCDI_SRC_VALID;
    mask_next = mask_reg;
    pend_next = pend_reg;
    if (enable_set_we) begin
      mask_next = mask_reg | cmd_valid;
    end
    if (enable_clear_we) begin
      mask_next = mask_reg & ~cmd_valid;
    end
    if (pending_clear_we) begin
      pend_next = pend_reg & ~cmd_valid;
    end
    // Event in the clearing cycle survives: set wins
    pend_next = pend_next | (src_event & LCDI_SRC_VALID);
    // Registered so the pin never glitches on decode
    irq_next  = |(pend_next & mask_next);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_reg <= LCDI_MASK_RST;
      pend_reg <= LCDI_PEND_RST;
      irq_reg  <= 1'b0;
    end else begin
      mask_reg <= mask_next;
      pend_reg <= pend_next;
      irq_reg  <= irq_next;
    end
  end

  assign enable_state  = mask_reg;
  assign pending_state = pend_reg;
  assign irq           = irq_reg;

endmodule
`default_nettype wire

/* verilog/lcdi_regs_top.sv */
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module lcdi_regs_top
  import lcdi_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic [ADDR_WIDTH-1:0]  s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [LCDI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic      [1:0]             s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0]  s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic      [LCDI_DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]             s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   line_evt,
  input  wire logic                   last_line_evt,
  input  wire logic                   frame_done_evt,
  input  wire logic                   fifo_empty_fault_evt,
  input  wire logic                   fifo_overrun_evt,
  input  wire logic                   dma_fault_evt,
  output logic      [7:0]             contrast_duty_value,
  output logic                        irq
);

  if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_addr_check
    $error("lcdi_regs_top: ADDR_WIDTH must lie between 8 and 32");
  end

  // Exact word match; misaligned or out-of-range addresses select nothing
  function automatic logic [LCDI_SEL_W-1:0] reg_decode(input logic [ADDR_WIDTH-1:0] addr);
    logic [LCDI_SEL_W-1:0] sel;
    sel = '0;
    if (addr == ADDR_WIDTH'(LCDI_OFS_CONTRAST)) begin
      sel[LCDI_SEL_CONTRAST] = 1'b1;
    end
    if (addr == ADDR_WIDTH'(LCDI_OFS_EN_SET)) begin
      sel[LCDI_SEL_EN_SET] = 1'b1;
    end
    if (addr == ADDR_WIDTH'(LCDI_OFS_EN_CLR)) begin
      sel[LCDI_SEL_EN_CLR] = 1'b1;
    end
    if (addr == ADDR_WIDTH'(LCDI_OFS_EN_STATE)) begin
      sel[LCDI_SEL_EN_STATE] = 1'b1;
    end
    if (addr == ADDR_WIDTH'(LCDI_OFS_PEND_STATE)) begin
      sel[LCDI_SEL_PEND_STATE] = 1'b1;
    end
    if (addr == ADDR_WIDTH'(LCDI_OFS_PEND_CLR)) begin
      sel[LCDI_SEL_PEND_CLR] = 1'b1;
    end
    return sel;
  endfunction

  lcdi_wr_state_t               wr_state_reg;
  lcdi_wr_state_t               wr_state_next;
  logic                         awready_reg;
  logic                         awready_next;
  logic                         wready_reg;
  logic                         wready_next;
  logic                         bvalid_reg;
  logic                         bvalid_next;
  logic [1:0]                   bresp_reg;
  logic [1:0]                   bresp_next;
  logic                         aw_held_reg;
  logic                         aw_held_next;
  logic                         w_held_reg;
  logic                         w_held_next;
  logic [ADDR_WIDTH-1:0]        waddr_reg;
  logic [ADDR_WIDTH-1:0]        waddr_next;
  logic [LCDI_DATA_W-1:0]       wdata_reg;
  logic [LCDI_DATA_W-1:0]       wdata_next;
  logic [3:0]                   wstrb_reg;
  logic [3:0]                   wstrb_next;
  logic [LCDI_CONTRAST_W-1:0]   contrast_reg;
  logic [LCDI_CONTRAST_W-1:0]   contrast_next;

  lcdi_rd_state_t               rd_state_reg;
  lcdi_rd_state_t               rd_state_next;
  logic                         arready_reg;
  logic                         arready_next;
  logic                         rvalid_reg;
  logic                         rvalid_next;
  logic [1:0]                   rresp_reg;
  logic [1:0]                   rresp_next;
  logic [LCDI_DATA_W-1:0]       rdata_reg;
  logic [LCDI_DATA_W-1:0]       rdata_next;

  logic                         aw_take;
  logic                         w_take;
  logic                         wr_fire;
  logic [ADDR_WIDTH-1:0]        wr_addr;
  logic [LCDI_DATA_W-1:0]       wr_word;
  logic [3:0]                   wr_strb;
  logic [LCDI_SEL_W-1:0]        wr_sel;
  logic                         cmd_ok;
  logic [LCDI_SEL_W-1:0]        rd_sel;

  logic [LCDI_SRC_W-1:0]        src_event;
  logic [LCDI_SRC_W-1:0]        enable_state;
  logic [LCDI_SRC_W-1:0]        pending_state;
  logic                         irq_bank;

  // Events come from logic on this clock, so no synchroniser
  always_comb begin
    src_event                      = '0;
    src_event[LCDI_BIT_LINE]       = line_evt;
    src_event[LCDI_BIT_LAST_LINE]  = last_line_evt;
    src_event[LCDI_BIT_FRAME_DONE] = frame_done_evt;
    src_event[LCDI_BIT_UNUSED]     = 1'b0;
    src_event[LCDI_BIT_FIFO_EMPTY] = fifo_empty_fault_evt;
    src_event[LCDI_BIT_FIFO_OVR]   = fifo_overrun_evt;
    src_event[LCDI_BIT_DMA_FAULT]  = dma_fault_evt;
  end

  // Write channel: address and data taken in either order
  always_comb begin
    wr_state_next = wr_state_reg;
    awready_next  = awready_reg;
    wready_next   = wready_reg;
    bvalid_next   = bvalid_reg;
    bresp_next    = bresp_reg;
    aw_held_next  = aw_held_reg;
    w_held_next   = w_held_reg;
    waddr_next    = waddr_reg;
    wdata_next    = wdata_reg;
    wstrb_next    = wstrb_reg;
    contrast_next = contrast_reg;
    aw_take       = s_axi_awvalid & awready_reg;
    w_take        = s_axi_wvalid & wready_reg;
    wr_addr       = aw_held_reg ? waddr_reg : s_axi_awaddr;
    wr_word       = w_held_reg ? wdata_reg : s_axi_wdata;
    wr_strb       = w_held_reg ? wstrb_reg : s_axi_wstrb;
    wr_sel        = reg_decode(wr_addr);
    wr_fire       = 1'b0;
    unique case (wr_state_reg)
      LCDI_WR_IDLE: begin
        if (aw_take) begin
          aw_held_next = 1'b1;
          waddr_next   = s_axi_awaddr;
        end
        if (w_take) begin
          w_held_next = 1'b1;
          wdata_next  = s_axi_wdata;
          wstrb_next  = s_axi_wstrb;
        end
        if ((aw_held_reg | aw_take) && (w_held_reg | w_take)) begin
          wr_fire       = 1'b1;
          aw_held_next  = 1'b0;
          w_held_next   = 1'b0;
          awready_next  = 1'b0;
          wready_next   = 1'b0;
          bvalid_next   = 1'b1;
          bresp_next    = (wr_sel == '0) ? LCDI_RESP_SLVERR : LCDI_RESP_OKAY;
          wr_state_next = LCDI_WR_RESP;
        end else begin
          awready_next = ~(aw_held_reg | aw_take);
          wready_next  = ~(w_held_reg | w_take);
        end
      end
      LCDI_WR_RESP: begin
        if (s_axi_bready) begin
          bvalid_next   = 1'b0;
          awready_next  = 1'b1;
          wready_next   = 1'b1;
          wr_state_next = LCDI_WR_IDLE;
        end
      end
      default: begin
        aw_held_next  = 1'b0;
        w_held_next   = 1'b0;
        awready_next  = 1'b0;
        wready_next   = 1'b0;
        bvalid_next   = 1'b0;
        wr_state_next = LCDI_WR_IDLE;
      end
    endcase
    // Only byte lane 0 carries implemented bits
    if (wr_fire && wr_sel[LCDI_SEL_CONTRAST] && wr_strb[0]) begin
      contrast_next = wr_word[LCDI_CONTRAST_W-1:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_state_reg <= LCDI_WR_IDLE;
      awready_reg  <= 1'b0;
      wready_reg   <= 1'b0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= LCDI_RESP_OKAY;
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      waddr_reg    <= '0;
      wdata_reg    <= '0;
      wstrb_reg    <= 4'h0;
      contrast_reg <= LCDI_CONTRAST_RST;
    end else begin
      wr_state_reg <= wr_state_next;
      awready_reg  <= awready_next;
      wready_reg   <= wready_next;
      bvalid_reg   <= bvalid_next;
      bresp_reg    <= bresp_next;
      aw_held_reg  <= aw_held_next;
      w_held_reg   <= w_held_next;
      waddr_reg    <= waddr_next;
      wdata_reg    <= wdata_next;
      wstrb_reg    <= wstrb_next;
      contrast_reg <= contrast_next;
    end
  end

  // Command registers act in the cycle the write completes
  assign cmd_ok = wr_fire & wr_strb[0];

  lcdi_irq_bank #(
    .SRC_W            (LCDI_SRC_W)
  ) u_irq_bank (
    .clock            (clock),
    .rst              (rst),
    .src_event        (src_event),
    .enable_set_we    (cmd_ok & wr_sel[LCDI_SEL_EN_SET]),
    .enable_clear_we  (cmd_ok & wr_sel[LCDI_SEL_EN_CLR]),
    .pending_clear_we (cmd_ok & wr_sel[LCDI_SEL_PEND_CLR]),
    .cmd_bits         (wr_word[LCDI_SRC_W-1:0]),
    .enable_state     (enable_state),
    .pending_state    (pending_state),
    .irq              (irq_bank)
  );

  // Read channel; write-only registers read as zero
  always_comb begin
    rd_state_next = rd_state_reg;
    arready_next  = arready_reg;
    rvalid_next   = rvalid_reg;
    rresp_next    = rresp_reg;
    rdata_next    = rdata_reg;
    rd_sel        = reg_decode(s_axi_araddr);
    unique case (rd_state_reg)
      LCDI_RD_IDLE: begin
        arready_next = 1'b1;
        if (s_axi_arvalid && arready_reg) begin
          arready_next  = 1'b0;
          rvalid_next   = 1'b1;
          rresp_next    = LCDI_RESP_OKAY;
          rdata_next    = '0;
          rd_state_next = LCDI_RD_DATA;
          if (rd_sel == '0) begin
            rresp_next = LCDI_RESP_SLVERR;
          end
          if (rd_sel[LCDI_SEL_CONTRAST]) begin
            rdata_next = LCDI_DATA_W'(contrast_reg);
          end
          if (rd_sel[LCDI_SEL_EN_STATE]) begin
            rdata_next = LCDI_DATA_W'(enable_state);
          end
          if (rd_sel[LCDI_SEL_PEND_STATE]) begin
            rdata_next = LCDI_DATA_W'(pending_state);
          end
        end
      end
      LCDI_RD_DATA: begin
        if (s_axi_rready) begin
          rvalid_next   = 1'b0;
          arready_next  = 1'b1;
          rd_state_next = LCDI_RD_IDLE;
        end
      end
      default: begin
        arready_next  = 1'b0;
        rvalid_next   = 1'b0;
        rd_state_next = LCDI_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_state_reg <= LCDI_RD_IDLE;
      arready_reg  <= 1'b0;
      rvalid_reg   <= 1'b0;
      rresp_reg    <= LCDI_RESP_OKAY;
      rdata_reg    <= '0;
    end else begin
      rd_state_reg <= rd_state_next;
      arready_reg  <= arready_next;
      rvalid_reg   <= rvalid_next;
      rresp_reg    <= rresp_next;
      rdata_reg    <= rdata_next;
    end
  end

  assign s_axi_awready       = awready_reg;
  assign s_axi_wready        = wready_reg;
  assign s_axi_bvalid        = bvalid_reg;
  assign s_axi_bresp         = bresp_reg;
  assign s_axi_arready       = arready_reg;
  assign s_axi_rvalid        = rvalid_reg;
  assign s_axi_rresp         = rresp_reg;
  assign s_axi_rdata         = rdata_reg;
  assign contrast_duty_value = contrast_reg;
  assign irq                 = irq_bank;

endmodule
`default_nettype wire

/* verification/lcdi_regs_props.sv */
`timescale 1ns/10ps
`default_nettype none
module lcdi_regs_props
  import lcdi_pkg::*;
(
  input wire logic                   clock,
  input wire logic                   rst,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wready,
  input wire logic [1:0]             s_axi_bresp,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic [LCDI_DATA_W-1:0] s_axi_rdata,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic                   line_evt,
  input wire logic                   last_line_evt,
  input wire logic                   frame_done_evt,
  input wire logic                   fifo_empty_fault_evt,
  input wire logic                   fifo_overrun_evt,
  input wire logic                   dma_fault_evt,
  input wire logic [7:0]             contrast_duty_value,
  input wire logic                   irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic evt_any;
  assign evt_any = line_evt | last_line_evt | frame_done_evt | fifo_empty_fault_evt
                   | fifo_overrun_evt | dma_fault_evt;
  a_contrast_by_write: assert property ($changed(contrast_duty_value) |-> $rose(s_axi_bvalid))
    else $error("Contrast value changed without a write");
  a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("Read data has unused bits set");
  a_irq_rise_cause: assert property ($rose(irq) |-> $past(evt_any) || $rose(s_axi_bvalid))
    else $error("Interrupt rose without event or write");
  a_irq_fall_cause: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
    else $error("Interrupt fell without a write");
  // Status latches, so only a write may drop the request
  a_irq_stays_set: assert property (irq ##1 !s_axi_bvalid [*3] |-> irq)
    else $error("Interrupt dropped while no write completed");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read not answered one cycle after acceptance");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data not held until taken");
  a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("New write accepted before response taken");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("New read accepted before data taken");
  cover property ($rose(irq));
  cover property ($fell(irq));
  cover property (s_axi_bvalid && s_axi_bresp == LCDI_RESP_SLVERR);
endmodule
bind lcdi_regs_top lcdi_regs_props u_props (.clock(clock), .rst(rst), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .line_evt(line_evt),
  .last_line_evt(last_line_evt), .frame_done_evt(frame_done_evt),
  .fifo_empty_fault_evt(fifo_empty_fault_evt), .fifo_overrun_evt(fifo_overrun_evt),
  .dma_fault_evt(dma_fault_evt), .contrast_duty_value(contrast_duty_value), .irq(irq));
`default_nettype wire

/* verification/lcd_irq_and_contrast_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module lcd_irq_and_contrast_regs_tb
  import lcdi_pkg::*;
;
  logic        clock, rst, awvalid, wvalid, bready, arvalid, rready, irq;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr, contrast;
  logic [31:0] wdata, rdata;
  logic [3:0]  strb;
  logic [1:0]  bresp, rresp;
  logic [5:0]  evt;
  int          bad_count, n_checks;

  lcdi_regs_top #(.ADDR_WIDTH(8)) DUT (
    .clock(clock), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .line_evt(evt[0]), .last_line_evt(evt[1]), .frame_done_evt(evt[2]),
    .fifo_empty_fault_evt(evt[3]), .fifo_overrun_evt(evt[4]), .dma_fault_evt(evt[5]),
    .contrast_duty_value(contrast), .irq(irq));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits are open ended; only the watchdog may end a hung handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clock);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge clock);
    end while (!bvalid);
    bready <= 1'b0;
    chk("write response", {30'h0, er}, {30'h0, bresp});
    @(posedge clock);
  endtask

  // Ready comes only once data stands, so the data-hold path is exercised
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clock);
    end while (!arready);
    arvalid <= 1'b0;
    do begin
      @(posedge clock);
    end while (!rvalid);
    rready <= 1'b1;
    @(posedge clock);
    rready <= 1'b0;
    chk("read data", ed, rdata);
    chk("read response", {30'h0, er}, {30'h0, rresp});
    @(posedge clock);
  endtask

  // Sampled at an edge so the design's own updates have settled
  task automatic pins(input logic ei, input logic [7:0] ec);
    @(posedge clock);
    chk("irq", {31'h0, ei}, {31'h0, irq});
    chk("contrast", {24'h0, ec}, {24'h0, contrast});
  endtask

  task automatic pulse(input logic [5:0] v);
    evt <= v;
    @(posedge clock);
    evt <= 6'h0;
    @(posedge clock);
  endtask

  task automatic t_after_reset;
    rd(LCDI_OFS_CONTRAST, 32'h0, LCDI_RESP_OKAY);
    rd(LCDI_OFS_EN_STATE, 32'h0, LCDI_RESP_OKAY);
    rd(LCDI_OFS_PEND_STATE, 32'h0, LCDI_RESP_OKAY);
    rd(LCDI_OFS_EN_SET, 32'h0, LCDI_RESP_OKAY);
    rd(8'h18, 32'h0, LCDI_RESP_SLVERR);
    pins(1'b0, 8'h00);
  endtask

  task automatic t_contrast;
    wr(LCDI_OFS_CONTRAST, 32'hffffffff, LCDI_RESP_OKAY);
    rd(LCDI_OFS_CONTRAST, 32'hff, LCDI_RESP_OKAY);
    pins(1'b0, 8'hff);
    strb <= 4'he;
    wr(LCDI_OFS_CONTRAST, 32'h5a, LCDI_RESP_OKAY);
    strb <= 4'hf;
    rd(LCDI_OFS_CONTRAST, 32'hff, LCDI_RESP_OKAY);
    wr(LCDI_OFS_CONTRAST, 32'h5a, LCDI_RESP_OKAY);
    pins(1'b0, 8'h5a);
    wr(LCDI_OFS_EN_STATE, 32'h7f, LCDI_RESP_OKAY);
    rd(LCDI_OFS_EN_STATE, 32'h0, LCDI_RESP_OKAY);
    wr(8'h1c, 32'h7f, LCDI_RESP_SLVERR);
  endtask

  task automatic t_enable;
    logic [31:0] m;
    m = 32'h0;
    for (int b = 0; b < 8; b++) begin
      wr(LCDI_OFS_EN_SET, 32'h1 << b, LCDI_RESP_OKAY);
      m = m | ((32'h1 << b) & {25'h0, LCDI_SRC_VALID});
      rd(LCDI_OFS_EN_STATE, m, LCDI_RESP_OKAY);
    end
    wr(LCDI_OFS_EN_CLR, 32'h0, LCDI_RESP_OKAY);
    rd(LCDI_OFS_EN_STATE, 32'h77, LCDI_RESP_OKAY);
    for (int b = 0; b < 8; b++) begin
      wr(LCDI_OFS_EN_CLR, 32'h1 << b, LCDI_RESP_OKAY);
      m = m & ~(32'h1 << b);
      rd(LCDI_OFS_EN_STATE, m, LCDI_RESP_OKAY);
    end
  endtask

  task automatic t_events;
    int          pos[6];
    logic [31:0] e;
    pos = '{LCDI_BIT_LINE, LCDI_BIT_LAST_LINE, LCDI_BIT_FRAME_DONE, LCDI_BIT_FIFO_EMPTY,
            LCDI_BIT_FIFO_OVR, LCDI_BIT_DMA_FAULT};
    for (int i = 0; i < 6; i++) begin
      e = 32'h1 << pos[i];
      pulse(6'h1 << i);
      rd(LCDI_OFS_PEND_STATE, e, LCDI_RESP_OKAY);
      pins(1'b0, 8'h5a);
      wr(LCDI_OFS_EN_SET, e, LCDI_RESP_OKAY);
      pins(1'b1, 8'h5a);
      wr(LCDI_OFS_PEND_CLR, 32'h0, LCDI_RESP_OKAY);
      rd(LCDI_OFS_PEND_STATE, e, LCDI_RESP_OKAY);
      wr(LCDI_OFS_PEND_CLR, e, LCDI_RESP_OKAY);
      rd(LCDI_OFS_PEND_STATE, 32'h0, LCDI_RESP_OKAY);
      pins(1'b0, 8'h5a);
      wr(LCDI_OFS_EN_CLR, e, LCDI_RESP_OKAY);
    end
    pulse(6'h3f);
    rd(LCDI_OFS_PEND_STATE, 32'h77, LCDI_RESP_OKAY);
    wr(LCDI_OFS_EN_SET, 32'h77, LCDI_RESP_OKAY);
    pins(1'b1, 8'h5a);
    wr(LCDI_OFS_EN_CLR, 32'h77, LCDI_RESP_OKAY);
    pins(1'b0, 8'h5a);
    wr(LCDI_OFS_PEND_CLR, 32'h77, LCDI_RESP_OKAY);
    rd(LCDI_OFS_PEND_STATE, 32'h0, LCDI_RESP_OKAY);
  endtask

  // Event high in the very cycle the clear lands must survive
  task automatic t_set_wins;
    evt <= 6'h1;
    fork
      wr(LCDI_OFS_PEND_CLR, 32'h1, LCDI_RESP_OKAY);
      begin
        @(posedge clock);
        evt <= 6'h0;
      end
    join
    rd(LCDI_OFS_PEND_STATE, 32'h1, LCDI_RESP_OKAY);
    wr(LCDI_OFS_PEND_CLR, 32'h1, LCDI_RESP_OKAY);
    rd(LCDI_OFS_PEND_STATE, 32'h0, LCDI_RESP_OKAY);
  endtask

  // Mid-run reset must drop every stored bit, not just the power-on state
  task automatic t_mid_reset;
    wr(LCDI_OFS_EN_SET, 32'h77, LCDI_RESP_OKAY);
    pulse(6'h3f);
    pins(1'b1, 8'h5a);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    pins(1'b0, 8'h00);
    rd(LCDI_OFS_EN_STATE, 32'h0, LCDI_RESP_OKAY);
    rd(LCDI_OFS_PEND_STATE, 32'h0, LCDI_RESP_OKAY);
    rd(LCDI_OFS_CONTRAST, 32'h0, LCDI_RESP_OKAY);
  endtask

  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, evt} = '0;
    strb = 4'hf;
    bad_count = 0;
    n_checks = 0;
    rst = 1'b1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_after_reset;
    t_contrast;
    t_enable;
    t_events;
    t_set_wins;
    t_mid_reset;
    report_and_stop;
  end

  // Far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    bad_count++;
    report_and_stop;
  end
endmodule
`default_nettype wire
